// *** common/cc_defs.svh ***
// register indexes, field positions, reset values and codes for cc
`ifndef CC_DEFS_SVH
`define CC_DEFS_SVH

// ==========================================================
// register indexes (byte address is four times the index)
`define CC_IDX_CA_CTRL      10'h0f3
`define CC_IDX_CA_HREF      10'h0f4
`define CC_IDX_CA_LREF      10'h0f5
`define CC_IDX_CA_RUN       10'h0f6
`define CC_IDX_T1_CTRL      10'h0fa

// ==========================================================
// carrier counter control fields
`define CC_CA_CLK_HI        7
`define CC_CA_CLK_LO        6
`define CC_CA_ITS_HI        5
`define CC_CA_ITS_LO        4
`define CC_CA_IE            3
`define CC_CA_PND           2
`define CC_CA_POL           1
`define CC_CA_ONESHOT       0

// ==========================================================
// carrier run register fields
`define CC_RUN_START        0
`define CC_RUN_STOP         1
`define CC_RUN_BUSY         0

// ==========================================================
// sixteen bit timer control fields
`define CC_T1_CLK_HI        7
`define CC_T1_CLK_LO        6
`define CC_T1_MODE_HI       5
`define CC_T1_MODE_LO       4
`define CC_T1_CLR           3
`define CC_T1_OVIE          2
`define CC_T1_MCIE          1
`define CC_T1_PND           0

// ==========================================================
// reset values and fixed codes
`define CC_CA_CTRL_RST      8'h00
`define CC_T1_CTRL_RST      8'h00
`define CC_REF_RST          8'h00
`define CC_CA_VECTOR        8'hec
`define CC_RESP_OKAY        2'b00
`define CC_RESP_SLVERR      2'b10
`define CC_PRE_W            4
`define CC_PHASE_EXTRA      9'h001

`endif

// *** common/cc_pkg.sv ***
// types shared by the carrier counter and timer control block
package cc_pkg;

   // ==========================================================
   // carrier phase state
   typedef enum logic [1:0] {
      CC_ST_IDLE = 2'b00,
      CC_ST_LOW  = 2'b01,
      CC_ST_HIGH = 2'b10
   } cc_phase_t;

   // ==========================================================
   // timer clock select
   typedef enum logic [1:0] {
      CC_T1_DIV4  = 2'b00,
      CC_T1_DIV8  = 2'b01,
      CC_T1_DIV16 = 2'b10,
      CC_T1_CNTA  = 2'b11
   } cc_t1_clk_t;

   // ==========================================================
   // carrier interrupt time select
   typedef enum logic [1:0] {
      CC_IT_LOW_END  = 2'b00,
      CC_IT_HIGH_END = 2'b01,
      CC_IT_BOTH     = 2'b10,
      CC_IT_BOTH_ALT = 2'b11
   } cc_int_time_t;

endpackage : cc_pkg

// *** core/cc_prescale.sv ***
// free running divider giving ticks at clock over 1, 2, 4, 8 and 16
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.svh"

module cc_prescale (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   output logic [4:0]      tick
);
   import cc_pkg::*;

   logic [`CC_PRE_W-1:0] cnt_q;

   // ==========================================================
   // divider counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // ==========================================================
   // tick k when the low k bits are all ones
   always_comb begin
      tick[0] = ce;
      for (int k = 1; k < 5; k++) begin
         tick[k] = ce & ((cnt_q & 4'((1 << k) - 1)) == 4'((1 << k) - 1));
      end
   end

endmodule : cc_prescale
`default_nettype wire

// *** core/cc_axil.sv ***
// axi4-lite slave front end for byte wide registers
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.svh"

module cc_axil (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   output logic             wr_fire,
   output logic [11:0]      wr_addr,
   output logic [7:0]       wr_data,
   input  wire logic        wr_hit,
   input  wire logic        rd_hit,
   input  wire logic [7:0]  rd_data
);
   import cc_pkg::*;

   logic aw_full_q;
   logic w_full_q;
   logic strb_q;
   logic rd_take;

   // ==========================================================
   // write channels taken in either order
   assign s_awready = ce & ~aw_full_q & ~s_bvalid;
   assign s_wready  = ce & ~w_full_q & ~s_bvalid;
   assign wr_fire   = ce & aw_full_q & w_full_q & ~s_bvalid & strb_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         wr_addr   <= 12'h000;
         wr_data   <= 8'h00;
         strb_q    <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= `CC_RESP_OKAY;
      end else if (ce) begin
         if (s_awvalid && s_awready) begin
            aw_full_q <= 1'b1;
            wr_addr   <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_full_q <= 1'b1;
            wr_data  <= s_wdata[7:0];
            strb_q   <= s_wstrb[0];
         end
         if (aw_full_q && w_full_q && !s_bvalid) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_hit ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read channel, one cycle to answer
   assign s_arready = ce & ~s_rvalid;
   assign rd_take   = s_arvalid & s_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h00000000;
         s_rresp  <= `CC_RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            s_rvalid <= 1'b1;
            s_rdata  <= {24'h000000, rd_hit ? rd_data : 8'h00};
            s_rresp  <= rd_hit ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

endmodule : cc_axil
`default_nettype wire

// *** core/cc_top.sv ***
// carrier counter with sixteen bit timer control register
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.svh"

// What this block does
// [R1] reset clears timer control to zero
// [R2] timer control holds clock and mode fields
// [R3] writing clear bit clears timer counter
// [R4] separate overflow and match capture enables
// [R5] timer pending reads status, write clears
// [R6] nine bit down counter auto reloads
// [R7] interval interrupt on level two, vector ech
// [R8] carrier output selectable as timer clock
// [R9] carrier control selects counter clock source
// [R10] carrier interrupt enable bit gates request
// [R11] carrier pending reads status, write clears
// [R12] field selects waveform point for interrupt
// [R13] polarity zero: phase is reference plus two
// [R14] polarity one swaps the phase references
// [R15] repeat mode gives continuous carrier
// [R16] one shot mode gives single pulse
// [R17] processor clock faster than counter clock; carrier clock select 00 counts on every processor clock
// [R18] internal timer clock uses carrier flip flop
// [R19] timer clock also fosc over 4, 8, 16
// [R20] one shot stops idle until restarted
// [R21] reference writes apply at next reload
module cc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   input  wire logic        t1_ovf_evt,
   input  wire logic        t1_mc_evt,
   output cc_pkg::cc_t1_clk_t t1_clk_sel,
   output logic [1:0]       t1_mode,
   output logic             t1_count_tick,
   output logic             t1_counter_clear,
   output logic             t1_ovf_irq,
   output logic             t1_mc_irq,
   output logic             carrier_out,
   output logic             ca_irq,
   output logic [7:0]       ca_irq_vector
);
   import cc_pkg::*;

   // ==========================================================
   // declarations
   logic                 wr_fire;
   logic [11:0]          wr_addr;
   logic [7:0]           wr_data;
   logic                 wr_hit;
   logic                 rd_hit;
   logic [7:0]           rd_data;
   logic [4:0]           pre_tick;

   logic [1:0]           ca_clk_q;
   cc_int_time_t         ca_its_q;
   logic                 ca_ie_q;
   logic                 ca_pnd_q;
   logic                 ca_pol_q;
   logic                 ca_oneshot_q;
   logic [7:0]           ca_href_q;
   logic [7:0]           ca_lref_q;

   cc_phase_t            state_q;
   logic [8:0]           cnt_q;
   logic                 out_q;
   logic                 out_prev_q;

   cc_t1_clk_t           t1_clk_q;
   logic [1:0]           t1_mode_q;
   logic                 t1_ovie_q;
   logic                 t1_mcie_q;
   logic                 t1_pnd_q;
   logic                 t1_tick_q;
   logic                 t1_clr_q;

   logic                 wr_ca_ctrl;
   logic                 wr_href;
   logic                 wr_lref;
   logic                 wr_run;
   logic                 wr_t1_ctrl;
   logic                 start_pulse;
   logic                 stop_pulse;
   logic                 ca_tick;
   logic                 end_low;
   logic                 end_high;
   logic                 ca_evt;
   logic                 ca_rise;
   logic                 t1_src_tick;

   // ==========================================================
   // functions
   function automatic logic idx_is(input logic [11:0] addr,
                                   input logic [9:0]  idx);
      idx_is = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
   endfunction : idx_is

   function automatic logic idx_mapped(input logic [11:0] addr);
      idx_mapped = idx_is(addr, `CC_IDX_CA_CTRL) |
                   idx_is(addr, `CC_IDX_CA_HREF) |
                   idx_is(addr, `CC_IDX_CA_LREF) |
                   idx_is(addr, `CC_IDX_CA_RUN)  |
                   idx_is(addr, `CC_IDX_T1_CTRL);
   endfunction : idx_mapped

   // phase length is reference plus two ticks: load reference plus one
   function automatic logic [8:0] phase_load(input logic       high_phase,
                                             input logic       pol,
                                             input logic [7:0] href,
                                             input logic [7:0] lref);
      logic [7:0] sel;
      sel = (high_phase ^ pol) ? href : lref; // [R13] [R14]
      phase_load = {1'b0, sel} + `CC_PHASE_EXTRA;
   endfunction : phase_load

   // ==========================================================
   // bus slave and prescaler
   cc_axil u_axil (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_fire   (wr_fire),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_hit    (wr_hit),
      .rd_hit    (rd_hit),
      .rd_data   (rd_data)
   );

   cc_prescale u_pre (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .tick    (pre_tick)
   );

   // ==========================================================
   // write decode
   assign wr_hit      = idx_mapped(wr_addr);
   assign wr_ca_ctrl  = wr_fire & idx_is(wr_addr, `CC_IDX_CA_CTRL);
   assign wr_href     = wr_fire & idx_is(wr_addr, `CC_IDX_CA_HREF);
   assign wr_lref     = wr_fire & idx_is(wr_addr, `CC_IDX_CA_LREF);
   assign wr_run      = wr_fire & idx_is(wr_addr, `CC_IDX_CA_RUN);
   assign wr_t1_ctrl  = wr_fire & idx_is(wr_addr, `CC_IDX_T1_CTRL);
   assign start_pulse = wr_run & wr_data[`CC_RUN_START];
   assign stop_pulse  = wr_run & wr_data[`CC_RUN_STOP];

   // ==========================================================
   // carrier control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ca_clk_q     <= 2'(`CC_CA_CTRL_RST >> `CC_CA_CLK_LO);
         ca_its_q     <= CC_IT_LOW_END;
         ca_ie_q      <= 1'b0;
         ca_pol_q     <= 1'b0;
         ca_oneshot_q <= 1'b0;
      end else if (ce && wr_ca_ctrl) begin
         ca_clk_q     <= wr_data[`CC_CA_CLK_HI:`CC_CA_CLK_LO]; // [R9]
         ca_its_q     <= cc_int_time_t'(wr_data[`CC_CA_ITS_HI:`CC_CA_ITS_LO]);
         ca_ie_q      <= wr_data[`CC_CA_IE]; // [R10]
         ca_pol_q     <= wr_data[`CC_CA_POL];
         ca_oneshot_q <= wr_data[`CC_CA_ONESHOT];
      end
   end

   // ==========================================================
   // reference registers, sampled at start and at each reload
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ca_href_q <= `CC_REF_RST;
         ca_lref_q <= `CC_REF_RST;
      end else if (ce) begin
         if (wr_href) begin
            ca_href_q <= wr_data; // [R21]
         end
         if (wr_lref) begin
            ca_lref_q <= wr_data; // [R21]
         end
      end
   end

   // ==========================================================
   // carrier counter and output flip flop
   assign ca_tick  = pre_tick[ca_clk_q]; // [R9]
   assign end_low  = ca_tick & (state_q == CC_ST_LOW) & (cnt_q == 9'h000);
   assign end_high = ca_tick & (state_q == CC_ST_HIGH) & (cnt_q == 9'h000);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CC_ST_IDLE;
         cnt_q   <= 9'h000;
         out_q   <= 1'b0;
      end else if (ce) begin
         if (stop_pulse) begin
            state_q <= CC_ST_IDLE;
            out_q   <= 1'b0;
         end else if (start_pulse) begin
            if (ca_oneshot_q) begin
               state_q <= CC_ST_HIGH; // [R16]
               cnt_q   <= phase_load(1'b1, ca_pol_q, ca_href_q, ca_lref_q);
               out_q   <= 1'b1;
            end else begin
               state_q <= CC_ST_LOW;
               cnt_q   <= phase_load(1'b0, ca_pol_q, ca_href_q, ca_lref_q);
               out_q   <= 1'b0;
            end
         end else if (ca_tick) begin
            case (state_q)
               CC_ST_LOW: begin
                  if (cnt_q == 9'h000) begin
                     state_q <= CC_ST_HIGH; // [R6] [R15]
                     cnt_q   <= phase_load(1'b1, ca_pol_q,
                                           ca_href_q, ca_lref_q);
                     out_q   <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q - 9'h001; // [R6]
                  end
               end
               CC_ST_HIGH: begin
                  if (cnt_q != 9'h000) begin
                     cnt_q <= cnt_q - 9'h001;
                  end else if (ca_oneshot_q) begin
                     state_q <= CC_ST_IDLE; // [R20]
                     out_q   <= 1'b0;
                  end else begin
                     state_q <= CC_ST_LOW; // [R6] [R15]
                     cnt_q   <= phase_load(1'b0, ca_pol_q,
                                           ca_href_q, ca_lref_q);
                     out_q   <= 1'b0;
                  end
               end
               CC_ST_IDLE: begin
                  out_q <= 1'b0; // [R20]
               end
               default: begin
                  state_q <= CC_ST_IDLE;
                  out_q   <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // carrier interrupt event and pending flag
   always_comb begin
      case (ca_its_q)
         CC_IT_LOW_END:  ca_evt = end_low; // [R12]
         CC_IT_HIGH_END: ca_evt = end_high; // [R12]
         CC_IT_BOTH:     ca_evt = end_low | end_high;
         default:        ca_evt = end_low | end_high;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ca_pnd_q <= 1'b0;
      end else if (ce) begin
         if (ca_evt) begin
            ca_pnd_q <= 1'b1; // [R7]
         end else if (wr_ca_ctrl && !wr_data[`CC_CA_PND]) begin
            ca_pnd_q <= 1'b0; // [R11]
         end
      end
   end

   assign ca_irq        = ca_pnd_q & ca_ie_q; // [R7] [R10]
   assign ca_irq_vector = `CC_CA_VECTOR; // [R7]
   assign carrier_out   = out_q;

   // ==========================================================
   // timer control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_clk_q  <= cc_t1_clk_t'(`CC_T1_CTRL_RST >> `CC_T1_CLK_LO); // [R1]
         t1_mode_q <= 2'b00; // [R1]
         t1_ovie_q <= 1'b0; // [R1]
         t1_mcie_q <= 1'b0; // [R1]
      end else if (ce && wr_t1_ctrl) begin
         t1_clk_q  <= cc_t1_clk_t'(wr_data[`CC_T1_CLK_HI:`CC_T1_CLK_LO]); // [R2]
         t1_mode_q <= wr_data[`CC_T1_MODE_HI:`CC_T1_MODE_LO]; // [R2]
         t1_ovie_q <= wr_data[`CC_T1_OVIE]; // [R4]
         t1_mcie_q <= wr_data[`CC_T1_MCIE]; // [R4]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_pnd_q <= 1'b0; // [R1]
      end else if (ce) begin
         if (t1_mc_evt) begin
            t1_pnd_q <= 1'b1;
         end else if (wr_t1_ctrl && !wr_data[`CC_T1_PND]) begin
            t1_pnd_q <= 1'b0; // [R5]
         end
      end
   end

   // ==========================================================
   // timer clock source and clear strobe
   assign ca_rise = out_q & ~out_prev_q;

   always_comb begin
      case (t1_clk_q)
         CC_T1_DIV4:  t1_src_tick = pre_tick[2]; // [R19]
         CC_T1_DIV8:  t1_src_tick = pre_tick[3]; // [R19]
         CC_T1_DIV16: t1_src_tick = pre_tick[4]; // [R19]
         CC_T1_CNTA:  t1_src_tick = ca_rise & ce; // [R8] [R18]
         default:     t1_src_tick = pre_tick[2];
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_prev_q <= 1'b0;
         t1_tick_q  <= 1'b0;
         t1_clr_q   <= 1'b0;
      end else if (ce) begin
         out_prev_q <= out_q;
         t1_tick_q  <= t1_src_tick; // [R8]
         t1_clr_q   <= wr_t1_ctrl & wr_data[`CC_T1_CLR]; // [R3]
      end
   end

   assign t1_clk_sel       = t1_clk_q;
   assign t1_mode          = t1_mode_q;
   assign t1_count_tick    = t1_tick_q;
   assign t1_counter_clear = t1_clr_q;
   assign t1_ovf_irq       = t1_ovf_evt & t1_ovie_q; // [R4]
   assign t1_mc_irq        = t1_pnd_q & t1_mcie_q; // [R4]

   // ==========================================================
   // read mux
   assign rd_hit = idx_mapped(s_araddr);

   always_comb begin
      rd_data = 8'h00;
      if (idx_is(s_araddr, `CC_IDX_CA_CTRL)) begin
         rd_data = {ca_clk_q, ca_its_q, ca_ie_q, ca_pnd_q, // [R11]
                    ca_pol_q, ca_oneshot_q};
      end else if (idx_is(s_araddr, `CC_IDX_CA_HREF)) begin
         rd_data = ca_href_q;
      end else if (idx_is(s_araddr, `CC_IDX_CA_LREF)) begin
         rd_data = ca_lref_q;
      end else if (idx_is(s_araddr, `CC_IDX_CA_RUN)) begin
         rd_data = {7'h00, state_q != CC_ST_IDLE};
      end else if (idx_is(s_araddr, `CC_IDX_T1_CTRL)) begin
         rd_data = {t1_clk_q, t1_mode_q, 1'b0, t1_ovie_q, // [R5]
                    t1_mcie_q, t1_pnd_q};
      end
   end

endmodule : cc_top
`default_nettype wire

// *** test/cc_checker.sv ***
// port checker for the cc block
`timescale 1ns/1ps
`default_nettype none
module cc_checker (
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           ce,
   input wire logic           s_awready,
   input wire logic           s_arvalid,
   input wire logic           s_arready,
   input wire logic           s_bvalid,
   input wire logic           s_rvalid,
   input wire logic [31:0]    s_rdata,
   input wire logic           t1_ovf_evt,
   input wire logic           t1_ovf_irq,
   input wire cc_pkg::cc_t1_clk_t t1_clk_sel,
   input wire logic           t1_counter_clear,
   input wire logic [7:0]     ca_irq_vector
);
   import cc_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // assertions
   AST_RST:
      assert property ($rose(aresetn) |-> t1_clk_sel == CC_T1_DIV4)
      else $error("timer clock not reset to div4");
   AST_VEC:
      assert property (ca_irq_vector == 8'hec)
      else $error("carrier vector wrong");
   AST_OVF:
      assert property (!t1_ovf_evt |-> !t1_ovf_irq)
      else $error("overflow request without event");
   AST_CLR:
      assert property (t1_counter_clear |=> !t1_counter_clear)
      else $error("counter clear longer than one cycle");
   AST_CE:
      assert property (!ce |-> !s_awready && !s_arready)
      else $error("ready while clock enable low");
   AST_BREF:
      assert property (s_bvalid |-> !s_awready)
      else $error("write address taken during response");
   AST_RREF:
      assert property (s_rvalid |-> !s_arready)
      else $error("read address taken during response");
   AST_RD:
      assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
      else $error("read answer late");
   AST_RHI:
      assert property (s_rvalid |-> s_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
endmodule : cc_checker
bind cc_top cc_checker i_cc_checker (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_awready(s_awready),
   .s_arvalid(s_arvalid), .s_arready(s_arready), .s_bvalid(s_bvalid),
   .s_rvalid(s_rvalid), .s_rdata(s_rdata), .t1_ovf_evt(t1_ovf_evt),
   .t1_ovf_irq(t1_ovf_irq), .t1_clk_sel(t1_clk_sel),
   .t1_counter_clear(t1_counter_clear), .ca_irq_vector(ca_irq_vector)
);
`default_nettype wire

// *** test/cc_top_bench.sv ***
// self-checking bench for the cc block
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.svh"
module cc_top_bench;
   import cc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0;
   logic t1_ovf_evt = 1'b0, t1_mc_evt = 1'b0;
   logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
   logic [31:0] s_wdata = 32'h0, s_rdata, q;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic t1_count_tick, t1_counter_clear, t1_ovf_irq, t1_mc_irq;
   logic carrier_out, ca_irq, pc = 1'b0;
   logic [1:0] s_bresp, s_rresp, t1_mode, rs;
   logic [7:0] ca_irq_vector, v, h, l;
   cc_t1_clk_t t1_clk_sel;
   int fails = 0, checks = 0, hi, lo, n, clrs = 0, ticks, rises;
   cc_top i_cc_top (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
      .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
      .s_rresp, .s_rvalid, .s_rready, .t1_ovf_evt, .t1_mc_evt,
      .t1_clk_sel, .t1_mode, .t1_count_tick, .t1_counter_clear,
      .t1_ovf_irq, .t1_mc_irq, .carrier_out, .ca_irq, .ca_irq_vector);
   always #2 aclk = ~aclk;
   always @(negedge aclk) begin
      clrs += t1_counter_clear;
      ticks += t1_count_tick;
      rises += carrier_out & !pc;
      pc = carrier_out;
   end
   // ==========================================================
   // helpers
   task finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task tmo;
      fails++;
      finish_test();
   endtask : tmo
   task bus(input bit we, input logic [11:0] a, input logic [7:0] d);
      bit ah, wh, b;
      n = 0;
      @(posedge aclk);
      s_awaddr <= a;
      s_araddr <= a;
      s_wdata <= {24'h0, d};
      s_awvalid <= we;
      s_wvalid <= we;
      s_bready <= we;
      s_arvalid <= !we;
      s_rready <= !we;
      do begin
         @(negedge aclk);
         ah = (s_awvalid & s_awready) | (s_arvalid & s_arready);
         wh = s_wvalid & s_wready;
         b = (s_bvalid & s_bready) | (s_rvalid & s_rready);
         q = s_rdata;
         rs = we ? s_bresp : s_rresp;
         n++;
         @(posedge aclk);
         if (ah) begin
            s_awvalid <= 1'b0;
            s_arvalid <= 1'b0;
         end
         if (wh) s_wvalid <= 1'b0;
         if (b) begin
            s_bready <= 1'b0;
            s_rready <= 1'b0;
         end
      end while (!b && n < 100);
      if (!b) tmo();
   endtask : bus
   task put(input logic [9:0] i, input logic [7:0] d);
      bus(1'b1, {i, 2'b00}, d);
      chk(rs, 2'b00);
   endtask : put
   task rd(input logic [9:0] i, input logic [31:0] e);
      bus(1'b0, {i, 2'b00}, 8'h00);
      chk(q, e);
   endtask : rd
   task till(input logic lvl, output int c);
      c = 0;
      while (carrier_out !== lvl) begin
         @(negedge aclk);
         c++;
         if (c > 3000) tmo();
      end
   endtask : till
   function automatic int ph(input logic [1:0] c, input logic [7:0] r);
      return (int'(r) + 2) << c;
   endfunction : ph
   // ==========================================================
   // tests
   initial begin
      void'($urandom(32'h9d79));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      ce <= 1'b0;
      @(posedge aclk);
      ce <= 1'b1;
      rd(`CC_IDX_T1_CTRL, 32'h0);
      rd(`CC_IDX_CA_CTRL, 32'h0);
      bus(1'b0, 12'h004, 8'h00);
      chk(rs, 2'b10);
      $display("reset test done");
      for (int k = 0; k < 4; k++) begin
         v = {k[1:0], 2'($urandom), 1'b0, 2'($urandom), 1'b0};
         put(`CC_IDX_T1_CTRL, v);
         rd(`CC_IDX_T1_CTRL, v);
         chk(t1_clk_sel, v[7:6]);
         chk(t1_mode, v[5:4]);
         @(posedge aclk);
         t1_ovf_evt <= 1'b1;
         @(negedge aclk);
         chk(t1_ovf_irq, v[2]);
         @(posedge aclk);
         t1_ovf_evt <= 1'b0;
         t1_mc_evt <= 1'b1;
         @(posedge aclk);
         t1_mc_evt <= 1'b0;
         rd(`CC_IDX_T1_CTRL, v | 8'h01);
         chk(t1_mc_irq, v[1]);
         put(`CC_IDX_T1_CTRL, v | 8'h08);
         rd(`CC_IDX_T1_CTRL, v);
      end
      chk(clrs, 4);
      $display("timer control test done");
      ticks = 0;
      rises = 0;
      for (int k = 0; k < 4; k++) begin
         h = 8'($urandom_range(12, 1));
         l = 8'($urandom_range(12, 1));
         v = {1'b0, k[1], k[1:0], k[1], 1'b0, k[0], 1'b0};
         put(`CC_IDX_CA_HREF, h);
         put(`CC_IDX_CA_LREF, l);
         put(`CC_IDX_CA_CTRL, v);
         put(`CC_IDX_CA_RUN, 8'h01);
         till(1'b0, n);
         till(1'b1, n);
         till(1'b0, hi);
         till(1'b1, lo);
         chk(hi, ph(v[7:6], k[0] ? l : h));
         chk(lo, ph(v[7:6], k[0] ? h : l));
         chk(ca_irq, k[1]);
         put(`CC_IDX_CA_RUN, 8'h02);
         rd(`CC_IDX_CA_CTRL, v | 8'h04);
         put(`CC_IDX_CA_CTRL, v);
         rd(`CC_IDX_CA_CTRL, v);
      end
      $display("carrier repeat test done");
      put(`CC_IDX_CA_CTRL, 8'h01);
      put(`CC_IDX_CA_RUN, 8'h01);
      till(1'b1, n);
      till(1'b0, hi);
      chk(hi, ph(2'b00, h));
      repeat (40) @(negedge aclk);
      chk(carrier_out, 1'b0);
      rd(`CC_IDX_CA_RUN, 32'h0);
      chk(ticks, rises);
      $display("carrier one shot test done");
      finish_test();
   end
endmodule : cc_top_bench
`default_nettype wire
